// *** mcsr_consts.vh ***
`ifndef MCSR_CONSTS_VH
`define MCSR_CONSTS_VH
// ------------------------------------------------------------
// Memory sizes and program vectors
// ------------------------------------------------------------
`define MCSR_PMEM_WORDS 2048
`define MCSR_DMEM_BYTES 128
`define MCSR_RESET_VEC 11'h000
`define MCSR_IRQ_VEC 11'h010
`define MCSR_SYS_FIRST 11'h7E0
`define MCSR_SYS_LAST 11'h7FF
`define MCSR_BIT_LAST 6'h3F
// ------------------------------------------------------------
// APB regions (byte address decode)
// ------------------------------------------------------------
`define MCSR_PMEM_TAG 3'h1
`define MCSR_LOW_TAG 4'h0
`define MCSR_RGN_IO 3'h0
`define MCSR_RGN_DATA 3'h1
`define MCSR_RGN_IND 3'h2
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define MCSR_IDX_ARITH_STATUS 6'h00
`define MCSR_IDX_STACK_POINTER 6'h02
`define MCSR_IDX_WAKE_WDT_LVR 6'h08
`define MCSR_IDX_PORT_A_DATA 6'h10
`define MCSR_IDX_PORT_A_DIR 6'h11
`define MCSR_IDX_PORT_A_PU 6'h12
`define MCSR_IDX_PORT_A_PD 6'h13
`define MCSR_IDX_PORT_B_DATA 6'h14
`define MCSR_IDX_PORT_B_DIR 6'h15
`define MCSR_IDX_PORT_B_PU 6'h16
`define MCSR_IDX_PORT_B_PD 6'h17
`define MCSR_IDX_COMPARATOR_CTRL 6'h18
`define MCSR_IO_MAP 64'h003C2000F3FF757D
// ------------------------------------------------------------
// Status and control fields
// ------------------------------------------------------------
`define MCSR_STATUS_RSVD 4'hF
`define MCSR_FLG_RANGE 3
`define MCSR_FLG_HALF 2
`define MCSR_FLG_CARRY 1
`define MCSR_FLG_ZERO 0
`define MCSR_CTL_WAKE 5
`define MCSR_CTL_LVR_OFF 2
`define MCSR_CTL_WDT_HI 1
`define MCSR_CTL_WDT_LO 0
`define MCSR_CTL_MASK 8'h27
`define MCSR_WAKE_SLOW 12'd3000
`define MCSR_WAKE_FAST 12'd45
`define MCSR_WDT_8K 19'd8192
`define MCSR_WDT_16K 19'd16384
`define MCSR_WDT_64K 19'd65536
`define MCSR_WDT_256K 19'd262144
// ------------------------------------------------------------
// Flag update operations
// ------------------------------------------------------------
`define MCSR_OP_ADD 2'h0
`define MCSR_OP_SUB 2'h1
`define MCSR_OP_LOGIC 2'h2
`define MCSR_OP_SHIFT 2'h3
`endif

// *** mcsr_core_regs.v ***
`timescale 1ns/1ps
`include "mcsr_consts.vh"
module mcsr_core_regs #(
    parameter PMEM_WORDS = `MCSR_PMEM_WORDS,
    parameter DMEM_BYTES = `MCSR_DMEM_BYTES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire pc_step,
    input wire call_req,
    input wire [10:0] call_target,
    input wire ret_req,
    input wire irq_take,
    output reg [10:0] pc_q,
    output reg [15:0] instr_q,
    input wire alu_upd,
    input wire [1:0] alu_op,
    input wire [7:0] alu_a,
    input wire [7:0] alu_b,
    input wire alu_cin,
    output reg [11:0] wake_periods_q,
    output reg undervoltage_reset_en_q,
    output reg [18:0] wdt_periods_q,
    input wire timer2_pulse_out,
    input wire timer3_pulse_out,
    input wire [7:0] port_a_t2_sel,
    input wire [7:0] port_a_t3_sel,
    input wire [7:0] port_b_t2_sel,
    input wire [7:0] port_b_t3_sel,
    input wire [7:0] port_a_pin_i,
    output reg [7:0] port_a_pin_o,
    output reg [7:0] port_a_pin_oe,
    output reg [7:0] port_a_pu_en,
    output reg [7:0] port_a_pd_en,
    input wire [7:0] port_b_pin_i,
    output reg [7:0] port_b_pin_o,
    output reg [7:0] port_b_pin_oe,
    output reg [7:0] port_b_pu_en,
    output reg [7:0] port_b_pd_en
);

// ------------------------------------------------------------
// Storage
// ------------------------------------------------------------
reg [15:0] pmem [0:PMEM_WORDS-1];
reg [7:0] dmem [0:DMEM_BYTES-1];
reg [7:0] io_q [0:63];
reg [3:0] flags_q;
reg [7:0] stack_pointer_q;
reg [7:0] ctl_q;
reg ind_wait_q;
reg [7:0] pa_s1_q;
reg [7:0] pa_s2_q;
reg [7:0] pb_s1_q;
reg [7:0] pb_s2_q;

// ------------------------------------------------------------
// Address decode
// ------------------------------------------------------------
wire in_pmem = (paddr[15:13] == `MCSR_PMEM_TAG);
wire in_low = (paddr[15:12] == `MCSR_LOW_TAG);
wire in_bit = in_low & paddr[11];
wire [2:0] rgn = paddr[11:9];
wire in_io = in_low & ~paddr[11] & (rgn == `MCSR_RGN_IO) & ~paddr[8];
wire in_data = in_low & ~paddr[11] & (rgn == `MCSR_RGN_DATA);
wire in_ind = in_low & ~paddr[11] & (rgn == `MCSR_RGN_IND);
wire [5:0] io_idx = paddr[7:2];
wire [6:0] d_idx = paddr[8:2];
wire [5:0] bit_byte = paddr[10:5];
wire [2:0] bit_pos = paddr[4:2];
wire [10:0] pm_idx = paddr[12:2];
wire [63:0] io_map = `MCSR_IO_MAP;
wire io_ok = in_io & io_map[io_idx];
wire pm_sys = (pm_idx >= `MCSR_SYS_FIRST) & (pm_idx <= `MCSR_SYS_LAST);
wire [7:0] ptr_byte = dmem[d_idx];
wire [6:0] ind_idx = ptr_byte[6:0];
wire acc_err = ~(in_pmem | in_bit | io_ok | in_data | in_ind) |
               (in_pmem & pwrite & pm_sys);

// ------------------------------------------------------------
// APB handshake
// ------------------------------------------------------------
wire access = psel & penable;
assign pready = ~(in_ind & ~ind_wait_q);
assign pslverr = access & pready & acc_err;
wire wr_go = access & pready & pwrite & ~acc_err;
wire io_wr = wr_go & in_io;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ind_wait_q <= 1'b0;
    end else begin
        ind_wait_q <= access & in_ind & ~ind_wait_q;
    end
end

// ------------------------------------------------------------
// Read data
// ------------------------------------------------------------
reg [7:0] io_rd;
reg [31:0] rd_val;

always @* begin
    case (io_idx)
        `MCSR_IDX_ARITH_STATUS: io_rd = {`MCSR_STATUS_RSVD, flags_q};
        `MCSR_IDX_STACK_POINTER: io_rd = stack_pointer_q;
        `MCSR_IDX_WAKE_WDT_LVR: io_rd = 8'h00;
        `MCSR_IDX_PORT_A_DATA: io_rd = pa_s2_q;
        `MCSR_IDX_PORT_B_DATA: io_rd = pb_s2_q;
        default: io_rd = io_q[io_idx];
    endcase
end

always @* begin
    rd_val = 32'h00000000;
    if (in_pmem) begin
        rd_val = {16'h0000, pmem[pm_idx]};
    end else if (in_bit) begin
        rd_val = {31'h00000000, dmem[{1'b0, bit_byte}][bit_pos]};
    end else if (io_ok) begin
        rd_val = {24'h000000, io_rd};
    end else if (in_data) begin
        rd_val = {24'h000000, dmem[d_idx]};
    end else if (in_ind) begin
        rd_val = {24'h000000, dmem[ind_idx]};
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (psel & ~pwrite) begin
        prdata <= acc_err ? 32'h00000000 : rd_val;
    end
end

// ------------------------------------------------------------
// Program store and fetch
// ------------------------------------------------------------
always @(posedge pclk) begin
    if (wr_go & in_pmem) begin
        pmem[pm_idx] <= pwdata[15:0];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        instr_q <= 16'h0000;
    end else begin
        instr_q <= pmem[pc_q];
    end
end

// ------------------------------------------------------------
// Program counter and stack
// ------------------------------------------------------------
wire [6:0] sp_lo = stack_pointer_q[6:0];
wire [6:0] sp_hi = sp_lo + 7'h01;
wire [6:0] pop_lo = sp_lo - 7'h02;
wire [6:0] pop_hi = sp_lo - 7'h01;
wire [15:0] ret_addr = irq_take ? {5'h00, pc_q} : {5'h00, pc_q + 11'h001};
wire [15:0] pop_addr = {dmem[pop_hi], dmem[pop_lo]};
wire push = irq_take | call_req;
wire pop = ret_req & ~push;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pc_q <= `MCSR_RESET_VEC;
    end else if (irq_take) begin
        pc_q <= `MCSR_IRQ_VEC;
    end else if (call_req) begin
        pc_q <= call_target;
    end else if (pop) begin
        pc_q <= pop_addr[10:0];
    end else if (pc_step) begin
        pc_q <= pc_q + 11'h001;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stack_pointer_q <= 8'h00;
    end else if (push) begin
        stack_pointer_q <= stack_pointer_q + 8'h02;
    end else if (pop) begin
        stack_pointer_q <= stack_pointer_q - 8'h02;
    end else if (io_wr & (io_idx == `MCSR_IDX_STACK_POINTER)) begin
        stack_pointer_q <= pwdata[7:0];
    end
end

// ------------------------------------------------------------
// Data memory writes
// ------------------------------------------------------------
always @(posedge pclk) begin
    if (push) begin
        dmem[sp_lo] <= ret_addr[7:0];
        dmem[sp_hi] <= ret_addr[15:8];
    end
    if (wr_go & in_data) begin
        dmem[d_idx] <= pwdata[7:0];
    end
    if (wr_go & in_ind) begin
        dmem[ind_idx] <= pwdata[7:0];
    end
    if (wr_go & in_bit) begin
        dmem[{1'b0, bit_byte}][bit_pos] <= pwdata[0];
    end
end

// ------------------------------------------------------------
// Arithmetic status flags
// ------------------------------------------------------------
wire [8:0] sum9 = {1'b0, alu_a} + {1'b0, alu_b};
wire [8:0] dif9 = {1'b0, alu_a} - {1'b0, alu_b};
wire [4:0] nib_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
reg [3:0] flags_d;

always @* begin
    flags_d = flags_q;
    case (alu_op)
        `MCSR_OP_ADD: begin
            flags_d[`MCSR_FLG_RANGE] = (alu_a[7] == alu_b[7]) &
                                       (sum9[7] != alu_a[7]);
            flags_d[`MCSR_FLG_HALF] = nib_sum[4];
            flags_d[`MCSR_FLG_CARRY] = sum9[8];
            flags_d[`MCSR_FLG_ZERO] = (sum9[7:0] == 8'h00);
        end
        `MCSR_OP_SUB: begin
            flags_d[`MCSR_FLG_RANGE] = (alu_a[7] != alu_b[7]) &
                                       (dif9[7] != alu_a[7]);
            flags_d[`MCSR_FLG_HALF] = (alu_a[3:0] < alu_b[3:0]);
            flags_d[`MCSR_FLG_CARRY] = dif9[8];
            flags_d[`MCSR_FLG_ZERO] = (dif9[7:0] == 8'h00);
        end
        `MCSR_OP_LOGIC: begin
            flags_d[`MCSR_FLG_ZERO] = (alu_a == 8'h00);
        end
        `MCSR_OP_SHIFT: begin
            flags_d[`MCSR_FLG_CARRY] = alu_cin;
        end
        default: begin
            flags_d = flags_q;
        end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flags_q <= 4'h0;
    end else if (alu_upd) begin
        flags_q <= flags_d;
    end else if (io_wr & (io_idx == `MCSR_IDX_ARITH_STATUS)) begin
        flags_q <= pwdata[3:0];
    end
end

// ------------------------------------------------------------
// Wake, watchdog and undervoltage control
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_q <= 8'h00;
    end else if (io_wr & (io_idx == `MCSR_IDX_WAKE_WDT_LVR)) begin
        ctl_q <= pwdata[7:0] & `MCSR_CTL_MASK;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wake_periods_q <= `MCSR_WAKE_SLOW;
        undervoltage_reset_en_q <= 1'b1;
        wdt_periods_q <= `MCSR_WDT_8K;
    end else begin
        wake_periods_q <= ctl_q[`MCSR_CTL_WAKE] ? `MCSR_WAKE_FAST
                                                : `MCSR_WAKE_SLOW;
        undervoltage_reset_en_q <= ~ctl_q[`MCSR_CTL_LVR_OFF];
        case (ctl_q[`MCSR_CTL_WDT_HI:`MCSR_CTL_WDT_LO])
            2'h0: wdt_periods_q <= `MCSR_WDT_8K;
            2'h1: wdt_periods_q <= `MCSR_WDT_16K;
            2'h2: wdt_periods_q <= `MCSR_WDT_64K;
            2'h3: wdt_periods_q <= `MCSR_WDT_256K;
            default: wdt_periods_q <= `MCSR_WDT_8K;
        endcase
    end
end

// ------------------------------------------------------------
// Generic register storage
// ------------------------------------------------------------
integer k;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (k = 0; k < 64; k = k + 1) begin
            io_q[k] <= 8'h00;
        end
    end else if (io_wr) begin
        io_q[io_idx] <= pwdata[7:0];
    end
end

// ------------------------------------------------------------
// Port pins
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pa_s1_q <= 8'h00;
        pa_s2_q <= 8'h00;
        pb_s1_q <= 8'h00;
        pb_s2_q <= 8'h00;
    end else begin
        pa_s1_q <= port_a_pin_i;
        pa_s2_q <= pa_s1_q;
        pb_s1_q <= port_b_pin_i;
        pb_s2_q <= pb_s1_q;
    end
end

wire [7:0] pa_pwm = port_a_t2_sel | port_a_t3_sel;
wire [7:0] pb_pwm = port_b_t2_sel | port_b_t3_sel;
wire [7:0] pa_pwm_lvl = (port_a_t2_sel & {8{timer2_pulse_out}}) |
                        (~port_a_t2_sel & {8{timer3_pulse_out}});
wire [7:0] pb_pwm_lvl = (port_b_t2_sel & {8{timer2_pulse_out}}) |
                        (~port_b_t2_sel & {8{timer3_pulse_out}});
wire [7:0] pa_dir = io_q[`MCSR_IDX_PORT_A_DIR];
wire [7:0] pb_dir = io_q[`MCSR_IDX_PORT_B_DIR];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        port_a_pin_o <= 8'h00;
        port_a_pin_oe <= 8'h00;
        port_a_pu_en <= 8'h00;
        port_a_pd_en <= 8'h00;
        port_b_pin_o <= 8'h00;
        port_b_pin_oe <= 8'h00;
        port_b_pu_en <= 8'h00;
        port_b_pd_en <= 8'h00;
    end else begin
        port_a_pin_o <= (pa_pwm & pa_pwm_lvl) |
                        (~pa_pwm & io_q[`MCSR_IDX_PORT_A_DATA]);
        port_a_pin_oe <= pa_pwm | pa_dir;
        port_a_pu_en <= io_q[`MCSR_IDX_PORT_A_PU] & ~pa_pwm;
        port_a_pd_en <= io_q[`MCSR_IDX_PORT_A_PD] & ~pa_pwm;
        port_b_pin_o <= (pb_pwm & pb_pwm_lvl) |
                        (~pb_pwm & io_q[`MCSR_IDX_PORT_B_DATA]);
        port_b_pin_oe <= pb_pwm | pb_dir;
        port_b_pu_en <= io_q[`MCSR_IDX_PORT_B_PU] & ~pb_pwm;
        port_b_pd_en <= io_q[`MCSR_IDX_PORT_B_PD] & ~pb_pwm;
    end
end

endmodule // mcsr_core_regs

// *** mcsr_core_regs_monitor.sv ***
`timescale 1ns/1ps
module mcsr_core_regs_monitor #(
    parameter PMEM_WORDS = 2048,
    parameter DMEM_BYTES = 128
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire call_req,
    input wire [10:0] call_target,
    input wire irq_take,
    input wire [10:0] pc_q,
    input wire [11:0] wake_periods_q,
    input wire undervoltage_reset_en_q,
    input wire [18:0] wdt_periods_q,
    input wire timer2_pulse_out,
    input wire [7:0] port_a_t2_sel,
    input wire [7:0] port_a_pin_o
);
// --------
// Properties
// --------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable && pready;
wire ctl_wr = acc && pwrite && paddr == 16'h0020;
property p_irq_vec; irq_take |=> pc_q == 11'h010; endproperty
a_irq_vec: assert property (p_irq_vec)
    else $error("pc missed interrupt vector");
property p_call; call_req && !irq_take |=> pc_q == $past(call_target); endproperty
a_call: assert property (p_call)
    else $error("pc missed call target");
property p_sys_ro; acc && pwrite && paddr >= 16'h3F80 && paddr <= 16'h3FFC |-> pslverr; endproperty
a_sys_ro: assert property (p_sys_ro)
    else $error("system words write accepted");
property p_ones; acc && !pwrite && paddr == 16'h0000 |-> prdata[7:4] == 4'hF; endproperty
a_ones: assert property (p_ones)
    else $error("status upper bits not ones");
property p_wake;
    ctl_wr |-> ##3 wake_periods_q == ($past(pwdata[5], 3) ? 12'd45 : 12'd3000);
endproperty
a_wake: assert property (p_wake)
    else $error("wake delay wrong");
property p_lvr; ctl_wr |-> ##3 undervoltage_reset_en_q == !$past(pwdata[2], 3); endproperty
a_lvr: assert property (p_lvr)
    else $error("undervoltage reset enable wrong");
property p_wdt;
    ctl_wr |-> ##3 wdt_periods_q ==
        (19'd8192 << ($past(pwdata[1:0], 3) * 2 - ($past(pwdata[1:0], 3) != 0)));
endproperty
a_wdt: assert property (p_wdt)
    else $error("watchdog period wrong");
property p_ind; psel && !penable && paddr[15:9] == 7'h02 |=> !pready ##1 pready; endproperty
a_ind: assert property (p_ind)
    else $error("indirect access not two cycles");
property p_direct; psel && !penable && paddr[15:9] == 7'h01 |=> pready; endproperty
a_direct: assert property (p_direct)
    else $error("direct access not one cycle");
property p_pulse;
    $stable(port_a_t2_sel) && $stable(timer2_pulse_out)
        |-> ((port_a_pin_o ^ {8{timer2_pulse_out}}) & port_a_t2_sel) == 8'h00;
endproperty
a_pulse: assert property (p_pulse)
    else $error("pin not carrying timer output");
c_irq: cover property (irq_take);
c_ind: cover property (acc && paddr[15:9] == 7'h02);
c_ctl: cover property (ctl_wr);
endmodule // mcsr_core_regs_monitor
bind mcsr_core_regs mcsr_core_regs_monitor #(.PMEM_WORDS(PMEM_WORDS), .DMEM_BYTES(DMEM_BYTES))
    mcsr_core_regs_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .call_req, .call_target, .irq_take, .pc_q, .wake_periods_q,
    .undervoltage_reset_en_q, .wdt_periods_q, .timer2_pulse_out, .port_a_t2_sel, .port_a_pin_o);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
// --------
// Signals
// --------
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
logic [15:0] paddr, instr_q;
logic [31:0] pwdata, prdata, rv;
logic pc_step, call_req, ret_req, irq_take, alu_upd, alu_cin;
logic [10:0] call_target, pc_q;
logic [1:0] alu_op;
logic [7:0] alu_a, alu_b;
logic [11:0] wake_periods_q;
logic undervoltage_reset_en_q;
logic [18:0] wdt_periods_q;
logic timer2_pulse_out, timer3_pulse_out;
logic [7:0] port_a_t2_sel, port_a_t3_sel, port_b_t2_sel, port_b_t3_sel;
logic [7:0] port_a_pin_i, port_a_pin_o, port_a_pin_oe, port_a_pu_en, port_a_pd_en;
logic [7:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe, port_b_pu_en, port_b_pd_en;
int n_mismatch = 0;
int total_checks = 0;
int cyc = 0;
int wdt_t [4] = '{8192, 16384, 65536, 262144};
logic [27:0] alu_t [8] = '{28'h07F010C, 28'h0FF0107, 28'h3000005, 28'h2050004,
    28'h180010C, 28'h1000106, 28'h1050501, 28'h3000013};
mcsr_core_regs mcsr_core_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pc_step, .call_req, .call_target, .ret_req,
    .irq_take, .pc_q, .instr_q, .alu_upd, .alu_op, .alu_a, .alu_b, .alu_cin,
    .wake_periods_q, .undervoltage_reset_en_q, .wdt_periods_q, .timer2_pulse_out,
    .timer3_pulse_out, .port_a_t2_sel, .port_a_t3_sel, .port_b_t2_sel, .port_b_t3_sel,
    .port_a_pin_i, .port_a_pin_o, .port_a_pin_oe, .port_a_pu_en, .port_a_pd_en,
    .port_b_pin_i, .port_b_pin_o, .port_b_pin_oe, .port_b_pu_en, .port_b_pd_en);
// --------
// Tasks
// --------
task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
        n_mismatch++;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
endtask
task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1, a, d, rv, ev);
endtask
task rc(input logic [15:0] a, input logic [31:0] x);
    apb(0, a, 32'h0, rv, ev);
    chk(rv, x);
endtask
task ck_err(input logic w, input logic [15:0] a);
    apb(w, a, 32'h1, rv, ev);
    chk(ev, 1);
endtask
task settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
endtask
task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// --------
// Sequence
// --------
initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
end
always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
        n_mismatch++;
        stop_test;
    end
end
initial begin
    {psel, penable, pwrite, pc_step, call_req, ret_req, irq_take, alu_upd, alu_cin} = '0;
    {paddr, pwdata, call_target, alu_op, alu_a, alu_b, timer2_pulse_out} = '0;
    {timer3_pulse_out, port_a_t2_sel, port_a_t3_sel, port_b_t2_sel, port_b_t3_sel} = '0;
    port_a_pin_i = 8'h96;
    port_b_pin_i = 8'h69;
    presetn = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(pc_q, 0);
    chk(wake_periods_q, 3000);
    chk(undervoltage_reset_en_q, 1);
    chk(wdt_periods_q, 8192);
    rc(16'h0000, 32'hF0);
    wr(16'h0000, 32'h0A);
    rc(16'h0000, 32'hFA);
    for (int i = 0; i < 4; i++) begin
        wr(16'h0020, {26'h0, i[0], 2'b00, i[1], i[1:0]});
        settle;
        chk(wake_periods_q, i[0] ? 45 : 3000);
        chk(undervoltage_reset_en_q, !i[1]);
        chk(wdt_periods_q, wdt_t[i]);
        rc(16'h0020, 32'h00);
    end
    wr(16'h0008, 32'h3C);
    rc(16'h0008, 32'h3C);
    wr(16'h0214, 32'h7F);
    wr(16'h03FC, 32'hA5);
    rc(16'h03FC, 32'hA5);
    rc(16'h0414, 32'hA5);
    wr(16'h02FC, 32'h00);
    wr(16'h0FFC, 32'h01);
    rc(16'h02FC, 32'h80);
    rc(16'h0FFC, 32'h01);
    ck_err(1, 16'h1000);
    ck_err(0, 16'h0004);
    ck_err(1, 16'h3F80);
    wr(16'h0244, 32'hCC);
    wr(16'h2044, 32'hBEEF);
    for (int i = 0; i < 8; i++)
        wr(16'h0040 + 16'(4 * i), 32'(17 * i));
    rc(16'h0244, 32'hCC);
    rc(16'h2044, 32'hBEEF);
    rc(16'h0040, 32'h96);
    rc(16'h0050, 32'h69);
    for (int i = 1; i < 8; i++)
        if (i != 4) rc(16'h0040 + 16'(4 * i), 32'(17 * i));
    settle;
    chk(port_a_pin_oe, 8'h11);
    chk(port_a_pu_en, 8'h22);
    chk(port_a_pd_en, 8'h33);
    chk(port_b_pin_o, 8'h44);
    chk(port_b_pin_oe, 8'h55);
    chk(port_b_pu_en, 8'h66);
    chk(port_b_pd_en, 8'h77);
    @(posedge pclk);
    port_a_t2_sel <= 8'h0F;
    port_b_t3_sel <= 8'hF0;
    timer2_pulse_out <= 1;
    settle;
    chk(port_a_pin_o, 8'h0F);
    chk(port_a_pin_oe, 8'h1F);
    chk(port_a_pu_en, 8'h20);
    chk(port_b_pin_o, 8'h04);
    chk(port_b_pin_oe, 8'hF5);
    chk(port_b_pd_en, 8'h07);
    @(posedge pclk);
    port_a_t2_sel <= 8'h00;
    port_b_t3_sel <= 8'h00;
    timer2_pulse_out <= 0;
    foreach (alu_t[k]) begin
        @(posedge pclk);
        alu_op <= alu_t[k][25:24];
        alu_a <= alu_t[k][23:16];
        alu_b <= alu_t[k][15:8];
        alu_cin <= alu_t[k][4];
        alu_upd <= 1;
        @(posedge pclk);
        alu_upd <= 0;
        rc(16'h0000, {24'h0, 4'hF, alu_t[k][3:0]});
    end
    wr(16'h0008, 32'h40);
    wr(16'h2040, 32'h1234);
    @(posedge pclk);
    pc_step <= 1;
    repeat (5) @(posedge pclk);
    pc_step <= 0;
    irq_take <= 1;
    @(posedge pclk);
    irq_take <= 0;
    @(negedge pclk);
    chk(pc_q, 11'h010);
    @(negedge pclk);
    chk(instr_q, 16'h1234);
    rc(16'h0008, 32'h42);
    rc(16'h0300, 32'h05);
    rc(16'h0304, 32'h00);
    @(posedge pclk);
    call_target <= 11'h123;
    call_req <= 1;
    @(posedge pclk);
    call_req <= 0;
    ret_req <= 1;
    @(negedge pclk);
    chk(pc_q, 11'h123);
    @(negedge pclk);
    chk(pc_q, 11'h011);
    @(posedge pclk);
    ret_req <= 0;
    @(negedge pclk);
    chk(pc_q, 11'h005);
    rc(16'h0008, 32'h40);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(pc_q, 0);
    chk(wdt_periods_q, 8192);
    stop_test;
end
endmodule // tb_top
